// [verilog/rsp_ctrl.sv]
// Reset combiner, time-out stretcher and sleep power gating
`timescale 1ns/1ps
module rsp_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hsel,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        por_n,
   input  wire logic        ext_reset_n,
   input  wire logic        wdt_expire,
   input  wire logic        bod_low,
   input  wire logic        jtag_reset_reg,
   input  wire logic [2:0]  brownout_level_fuses,
   input  wire logic [1:0]  startup_time_fuses,
   input  wire logic [3:0]  clock_select_fuses,
   input  wire logic        debug_enable_fuse,
   input  wire logic        jtag_enable_fuse,
   input  wire logic        tap_shifting,
   input  wire logic        tdo_data,
   input  wire logic [7:0]  wake_pin_mask,
   output logic             port_reset_n,
   output logic             core_reset_n,
   output logic             tdo_out,
   output logic             tdo_oe,
   output logic             jtag_enabled,
   output logic [7:0]       buf_enable_zero,
   output logic [7:0]       buf_enable_one,
   output logic             comp_enable,
   output logic             vref_enable,
   output logic             bod_enable,
   output logic             wdt_run,
   output logic             main_clk_enable
);
   import rsp_pkg::*;

   // Port reset path: the five sources are pure gates into an async clear, no clock needed
   logic wdt_req;
   logic bod_req;
   logic any_req;
   logic ctrl_wdt_en;
   logic bod_on;
   assign bod_on  = (brownout_level_fuses != BOD_DISABLED);
   assign wdt_req = wdt_expire & ctrl_wdt_en;
   assign bod_req = bod_low & bod_on;
   assign any_req = ~por_n | ~ext_reset_n | wdt_req | bod_req
                    | jtag_reset_reg;

   // Async reset of the stretcher; pin and POR act even with hclk stopped
   logic arst_n;
   assign arst_n = hresetn & por_n & ext_reset_n;

   rsp_state_t  state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [15:0] term_cnt;
   logic        core_rst_n_next;

   // Terminal count from combined fuse setting
   always_comb begin
      case ({startup_time_fuses, clock_select_fuses[0]})
         3'b000, 3'b001: term_cnt = TOUT_SHORT_CYC;
         3'b010, 3'b011: term_cnt = TOUT_MID_CYC;
         3'b100, 3'b101: term_cnt = TOUT_LONG_CYC;
         default:        term_cnt = TOUT_XLONG_CYC;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         RSP_ST_HOLD: begin
            cnt_next = 16'h0000;
            if (!any_req) begin
               state_next = RSP_ST_COUNT;
            end
         end
         RSP_ST_COUNT: begin
            if (any_req) begin
               state_next = RSP_ST_HOLD;
               cnt_next   = 16'h0000;
            end else if (cnt_reg + 16'h0001 >= term_cnt) begin
               state_next = RSP_ST_RUN;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
         default: begin
            if (any_req) begin
               state_next = RSP_ST_HOLD;
            end
         end
      endcase
      core_rst_n_next = (state_next == RSP_ST_RUN);
   end

   always_ff @(posedge hclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= RSP_ST_HOLD;
         cnt_reg      <= 16'h0000;
         core_reset_n <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         core_reset_n <= core_rst_n_next;
      end
   end

   // Port reset: async assert from any source, sync release
   // Release waits two edges so a runt request cannot glitch the pins
   logic port_sync_reg;
   logic any_req_n;
   assign any_req_n = ~any_req;
   always_ff @(posedge hclk or posedge any_req) begin
      if (any_req) begin
         port_sync_reg <= 1'b0;
         port_reset_n  <= 1'b0;
      end else begin
         port_sync_reg <= any_req_n;
         port_reset_n  <= port_sync_reg;
      end
   end

   // Register bus slave
   // Zero wait states: read data is registered at the address phase edge
   logic                  ap_wr_reg, ap_wr_next;
   logic [11:0]           ap_addr_reg, ap_addr_next;
   logic [CTRL_WIDTH-1:0] ctrl_reg, ctrl_next;
   logic [7:0]            input_disable_reg_zero_reg, input_disable_reg_zero_next;
   logic [7:0]            input_disable_reg_one_reg, input_disable_reg_one_next;
   logic [31:0]           rdata_next;
   logic                  ap_take;
   assign ap_take     = hsel & hready & htrans[1];
   assign ctrl_wdt_en = ctrl_reg[CTRL_WDT_EN_BIT];

   always_comb begin
      ap_wr_next   = ap_take & hwrite;
      ap_addr_next = ap_take ? haddr[11:0] : ap_addr_reg;
      ctrl_next    = ctrl_reg;
      input_disable_reg_zero_next   = input_disable_reg_zero_reg;
      input_disable_reg_one_next   = input_disable_reg_one_reg;
      if (ap_wr_reg) begin
         if (ap_addr_reg == CTRL_OFF) begin
            ctrl_next = hwdata[CTRL_WIDTH-1:0];
         end else if (ap_addr_reg == INPUT_DISABLE_REG_ZERO_OFF) begin
            input_disable_reg_zero_next = hwdata[7:0];
         end else if (ap_addr_reg == INPUT_DISABLE_REG_ONE_OFF) begin
            input_disable_reg_one_next = hwdata[7:0];
         end
      end
      rdata_next = 32'h0000_0000;
      if (ap_take && !hwrite) begin
         if (haddr[11:0] == CTRL_OFF) begin
            rdata_next = {23'h000000, ctrl_reg};
         end else if (haddr[11:0] == INPUT_DISABLE_REG_ZERO_OFF) begin
            rdata_next = {24'h000000, input_disable_reg_zero_reg};
         end else if (haddr[11:0] == INPUT_DISABLE_REG_ONE_OFF) begin
            rdata_next = {24'h000000, input_disable_reg_one_reg};
         end else if (haddr[11:0] == STAT_OFF) begin
            rdata_next = {24'h000000, vref_enable, comp_enable, jtag_enabled,
                          main_clk_enable, 2'b00, state_reg};
         end else if (haddr[11:0] == TOUT_OFF) begin
            rdata_next = {16'h0000, term_cnt};
         end
      end
   end

   // Registers sit in the core reset domain so they return to initial values
   always_ff @(posedge hclk or negedge core_reset_n) begin
      if (!core_reset_n) begin
         ap_wr_reg   <= 1'b0;
         ap_addr_reg <= 12'h000;
         ctrl_reg    <= CTRL_RESET;
         input_disable_reg_zero_reg   <= DIDR_RESET;
         input_disable_reg_one_reg   <= DIDR_RESET;
         hrdata      <= 32'h0000_0000;
      end else begin
         ap_wr_reg   <= ap_wr_next;
         ap_addr_reg <= ap_addr_next;
         ctrl_reg    <= ctrl_next;
         input_disable_reg_zero_reg   <= input_disable_reg_zero_next;
         input_disable_reg_one_reg   <= input_disable_reg_one_next;
         hrdata      <= rdata_next;
      end
   end

   // Sleep power gating
   logic       sleeping;
   logic [2:0] sleep_select_bits;
   logic       deep_sleep;
   logic       io_adc_stopped;
   logic       jtag_on;
   logic       comp_on;
   logic       adc_on;
   assign sleeping          = ctrl_reg[CTRL_SLEEP_EN_BIT];
   assign sleep_select_bits = ctrl_reg[CTRL_SLEEP_LO_BIT+2:CTRL_SLEEP_LO_BIT];
   assign adc_on            = ctrl_reg[CTRL_ADC_EN_BIT];
   assign jtag_on           = jtag_enable_fuse & ~ctrl_reg[CTRL_JTD_BIT];

   // Unknown select codes behave as Idle, the safe shallow choice
   always_comb begin
      case (sleep_select_bits)
         RSP_SLP_IDLE:    begin deep_sleep = 1'b0; io_adc_stopped = 1'b0; end
         RSP_SLP_ADCNR:   begin deep_sleep = 1'b0; io_adc_stopped = 1'b0; end
         RSP_SLP_PWRDN:   begin deep_sleep = 1'b1; io_adc_stopped = 1'b1; end
         RSP_SLP_PWRSAVE: begin deep_sleep = 1'b1; io_adc_stopped = 1'b1; end
         RSP_SLP_STANDBY: begin deep_sleep = 1'b1; io_adc_stopped = 1'b1; end
         default:         begin deep_sleep = 1'b0; io_adc_stopped = 1'b0; end
      endcase
      deep_sleep     = deep_sleep & sleeping;
      io_adc_stopped = io_adc_stopped & sleeping;
   end

   assign comp_on = ~ctrl_reg[CTRL_ACD_BIT] & ~deep_sleep;

   logic [7:0] buf0_next;
   logic [7:0] buf1_next;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_buf
         assign buf0_next[gi] = ~input_disable_reg_zero_reg[gi]
                                & (~io_adc_stopped | wake_pin_mask[gi]);
         assign buf1_next[gi] = ~input_disable_reg_one_reg[gi] & ~io_adc_stopped;
      end
   endgenerate

   always_ff @(posedge hclk or negedge core_reset_n) begin
      if (!core_reset_n) begin
         tdo_out         <= 1'b0;
         tdo_oe          <= 1'b0;
         jtag_enabled    <= 1'b0;
         buf_enable_zero <= 8'h00;
         buf_enable_one  <= 8'h00;
         comp_enable     <= 1'b0;
         vref_enable     <= 1'b0;
         bod_enable      <= 1'b0;
         wdt_run         <= 1'b0;
         main_clk_enable <= 1'b1;
         hreadyout       <= 1'b1;
         hresp           <= 1'b0;
      end else begin
         tdo_out         <= tdo_data;
         tdo_oe          <= jtag_on & tap_shifting;
         jtag_enabled    <= jtag_on;
         buf_enable_zero <= buf0_next;
         buf_enable_one  <= buf1_next;
         comp_enable     <= comp_on;
         // Internal reference stays up for comparator bandgap use even asleep
         vref_enable     <= bod_on | (ctrl_reg[CTRL_ACBG_BIT] & ~ctrl_reg[CTRL_ACD_BIT])
                            | adc_on;
         bod_enable      <= bod_on;
         wdt_run         <= ctrl_wdt_en;
         main_clk_enable <= ~sleeping | (debug_enable_fuse & jtag_on)
                            | (sleep_select_bits == RSP_SLP_STANDBY)
                            | ~deep_sleep;
         hreadyout       <= 1'b1;
         hresp           <= 1'b0;
      end
   end

   // Port pins drop at once and stay low one edge beyond the request
   property p_port_reset;
      @(posedge hclk) any_req |-> ##1 !port_reset_n;
   endproperty
   a_port_reset: assert property (p_port_reset) else $error("port reset not low after request");
   property p_core_held;
      @(posedge hclk) disable iff (!arst_n) any_req |=> !core_reset_n;
   endproperty
   a_core_held: assert property (p_core_held) else $error("core released while source active");
   property p_wdt_gate;
      @(posedge hclk) disable iff (!arst_n) (wdt_expire && !ctrl_wdt_en && por_n && ext_reset_n
         && !bod_req && !jtag_reset_reg && state_reg == RSP_ST_RUN) |=> core_reset_n;
   endproperty
   a_wdt_gate: assert property (p_wdt_gate) else $error("disabled watchdog reset");
   // Output enable follows the TAP shift state one edge late
   property p_tdo;
      @(posedge hclk) disable iff (!core_reset_n) tdo_oe |-> $past(jtag_on & tap_shifting);
   endproperty
   a_tdo: assert property (p_tdo) else $error("tdo driven outside shift");
   property p_jtag_off;
      @(posedge hclk) disable iff (!core_reset_n) !jtag_enable_fuse ##1 !jtag_enable_fuse |-> !jtag_enabled;
   endproperty
   a_jtag_off: assert property (p_jtag_off) else $error("jtag on with fuse clear");
   property p_bod;
      @(posedge hclk) disable iff (!core_reset_n) $past(bod_on) && $past(core_reset_n) |-> bod_enable;
   endproperty
   a_bod: assert property (p_bod) else $error("bod off while fused");
   property p_vref;
      @(posedge hclk) disable iff (!core_reset_n) vref_enable |-> $past(bod_on | adc_on | ctrl_reg[CTRL_ACBG_BIT]);
   endproperty
   a_vref: assert property (p_vref) else $error("vref on without user");
   property p_restart;
      @(posedge hclk) disable iff (!arst_n) (state_reg == RSP_ST_COUNT && any_req) |=> cnt_reg == 16'h0000;
   endproperty
   a_restart: assert property (p_restart) else $error("counter not restarted");
   // Pin and supply monitor act without waiting for a clock edge
   property p_pin_async;
      @(posedge hclk) (!ext_reset_n || !por_n) |-> !core_reset_n;
   endproperty
   a_pin_async: assert property (p_pin_async) else $error("core not held by pin or supply");
   property p_release;
      @(posedge hclk) disable iff (!arst_n) $rose(core_reset_n) |->
         $past(state_reg) == RSP_ST_COUNT && $past(cnt_reg) + 16'h0001 >= $past(term_cnt);
   endproperty
   a_release: assert property (p_release) else $error("core released before time-out");
   property p_wdt_pulse;
      @(posedge hclk) disable iff (!arst_n) (wdt_req && state_reg == RSP_ST_RUN) |=> state_reg == RSP_ST_HOLD;
   endproperty
   a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse ignored");
   property p_wdt_run;
      @(posedge hclk) disable iff (!core_reset_n) $past(core_reset_n) |-> wdt_run == $past(ctrl_wdt_en);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("watchdog stopped while enabled");
   property p_comp_deep;
      @(posedge hclk) disable iff (!core_reset_n) $past(core_reset_n) && $past(deep_sleep) |-> !comp_enable;
   endproperty
   a_comp_deep: assert property (p_comp_deep) else $error("comparator on in deep sleep");
   // Only wake-up pins may keep a buffer once both clocks stop
   property p_buf_sleep;
      @(posedge hclk) disable iff (!core_reset_n) $past(core_reset_n) && $past(io_adc_stopped)
         |-> (buf_enable_zero & ~$past(wake_pin_mask)) == 8'h00 && buf_enable_one == 8'h00;
   endproperty
   a_buf_sleep: assert property (p_buf_sleep) else $error("input buffer on in deep sleep");
   property p_didr;
      @(posedge hclk) disable iff (!core_reset_n) $past(core_reset_n) |->
         (buf_enable_zero & $past(input_disable_reg_zero_reg)) == 8'h00 && (buf_enable_one & $past(input_disable_reg_one_reg)) == 8'h00;
   endproperty
   a_didr: assert property (p_didr) else $error("disabled input buffer on");
   property p_dbg_clk;
      @(posedge hclk) disable iff (!core_reset_n) $past(core_reset_n) && $past(debug_enable_fuse & jtag_on)
         |-> main_clk_enable;
   endproperty
   a_dbg_clk: assert property (p_dbg_clk) else $error("main clock stopped with debug on");
   c_release: cover property (@(posedge hclk) $rose(core_reset_n));
   c_restart: cover property (@(posedge hclk) state_reg == RSP_ST_COUNT && any_req);
   c_deep:    cover property (@(posedge hclk) deep_sleep);
   c_wdt:     cover property (@(posedge hclk) wdt_req && state_reg == RSP_ST_RUN);
   c_bufs:    cover property (@(posedge hclk) io_adc_stopped && |wake_pin_mask);
endmodule : rsp_ctrl

// [verilog/rsp_pkg.sv]
// Package for the reset and sleep power control block
package rsp_pkg;
   // Register byte offsets
   localparam logic [11:0] CTRL_OFF   = 12'h000;
   localparam logic [11:0] INPUT_DISABLE_REG_ZERO_OFF  = 12'h004;
   localparam logic [11:0] INPUT_DISABLE_REG_ONE_OFF  = 12'h008;
   localparam logic [11:0] STAT_OFF   = 12'h00c;
   localparam logic [11:0] TOUT_OFF   = 12'h010;
   // Control register fields
   localparam int CTRL_SLEEP_EN_BIT   = 0;
   localparam int CTRL_SLEEP_LO_BIT   = 1;
   localparam int CTRL_JTD_BIT        = 4;
   localparam int CTRL_ACBG_BIT       = 5;
   localparam int CTRL_ACD_BIT        = 6;
   localparam int CTRL_ADC_EN_BIT     = 7;
   localparam int CTRL_WDT_EN_BIT     = 8;
   localparam int CTRL_WIDTH          = 9;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;
   localparam logic [7:0] DIDR_RESET  = 8'h00;
   // Sleep mode encodings
   typedef enum logic [2:0] {
      RSP_SLP_IDLE    = 3'b000,
      RSP_SLP_ADCNR   = 3'b001,
      RSP_SLP_PWRDN   = 3'b010,
      RSP_SLP_PWRSAVE = 3'b011,
      RSP_SLP_STANDBY = 3'b110
   } rsp_sleep_t;
   localparam logic [2:0] BOD_DISABLED = 3'b111;
   // Reset stretcher states
   typedef enum logic [1:0] {
      RSP_ST_HOLD  = 2'b00,
      RSP_ST_COUNT = 2'b01,
      RSP_ST_RUN   = 2'b10
   } rsp_state_t;
   // Time-out counts per fuse selection, in cycles
   localparam int CLK_MHZ        = 200;
   localparam int TOUT_SHORT_NS  = 20;
   localparam int TOUT_MID_NS    = 100;
   localparam int TOUT_LONG_NS   = 400;
   localparam int TOUT_XLONG_NS  = 2000;
   localparam logic [15:0] TOUT_SHORT_CYC = 16'((TOUT_SHORT_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] TOUT_MID_CYC   = 16'((TOUT_MID_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] TOUT_LONG_CYC  = 16'((TOUT_LONG_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] TOUT_XLONG_CYC = 16'((TOUT_XLONG_NS * CLK_MHZ + 999) / 1000);
   localparam int NUM_SOURCES    = 5;
endpackage : rsp_pkg

// [verification/rsp_far_model.sv]
// Far-side model: supply monitors, reset pin, watchdog pulse and debug port
`timescale 1ns/1ps
module rsp_far_model (
   input  wire logic       hclk,
   input  wire logic [3:0] src_on,
   input  wire logic       wdt_fire,
   input  wire logic       shift_req,
   input  wire logic       tdo_bit,
   output logic            por_n,
   output logic            ext_reset_n,
   output logic            wdt_expire,
   output logic            bod_low,
   output logic            jtag_reset_reg,
   output logic            tap_shifting,
   output logic            tdo_data
);
   logic fire_q   = 1'b0;
   logic pulse_q  = 1'b0;
   logic idle_tgl = 1'b0;
   assign ext_reset_n    = ~src_on[0];
   assign por_n          = ~src_on[1];
   assign jtag_reset_reg = src_on[2];
   assign bod_low        = src_on[3];
   assign tap_shifting   = shift_req;
   assign wdt_expire     = pulse_q;
   // Outside shifting the line toggles, so a stale value is never mistaken for data
   assign tdo_data       = shift_req ? tdo_bit : idle_tgl;
   always_ff @(posedge hclk) begin
      fire_q   <= wdt_fire;
      idle_tgl <= ~idle_tgl;
      pulse_q  <= wdt_fire & ~fire_q;
   end
endmodule : rsp_far_model

// [verification/test_reset_and_sleep_power_control.sv]
// Self-checking bench for the reset and sleep power control block
`timescale 1ns/1ps
module test_reset_and_sleep_power_control;
   import rsp_pkg::*;
   logic        hclk                 = 1'b0;
   logic        hresetn              = 1'b0;
   logic [31:0] haddr                = 32'h0;
   logic [1:0]  htrans               = 2'h0;
   logic        hwrite               = 1'b0;
   logic [2:0]  hsize                = 3'h2;
   logic [31:0] hwdata               = 32'h0;
   logic        hsel                 = 1'b0;
   logic [3:0]  src_on               = 4'h0;
   logic        wdt_fire             = 1'b0;
   logic        shift_req            = 1'b0;
   logic        tdo_bit              = 1'b0;
   logic [2:0]  brownout_level_fuses = 3'h7;
   logic [1:0]  startup_time_fuses   = 2'h0;
   logic [3:0]  clock_select_fuses   = 4'h0;
   logic        debug_enable_fuse    = 1'b0;
   logic        jtag_enable_fuse     = 1'b1;
   logic [7:0]  wake_pin_mask        = 8'h81;
   logic [31:0] hrdata, r;
   logic        hreadyout, hresp, por_n, ext_reset_n, wdt_expire, bod_low, jtag_reset_reg;
   logic        tap_shifting, tdo_data, port_reset_n, core_reset_n, tdo_out, tdo_oe, jtag_enabled;
   logic        comp_enable, vref_enable, bod_enable, wdt_run, main_clk_enable;
   logic [7:0]  buf_enable_zero, buf_enable_one;
   int          failures = 0;
   int          comparisons = 0;
   int          cycles = 0;
   rsp_sleep_t  md [5] = '{RSP_SLP_IDLE, RSP_SLP_ADCNR, RSP_SLP_PWRDN, RSP_SLP_PWRSAVE, RSP_SLP_STANDBY};

   rsp_ctrl dut_u (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .por_n, .ext_reset_n, .wdt_expire, .bod_low, .jtag_reset_reg,
      .brownout_level_fuses, .startup_time_fuses, .clock_select_fuses, .debug_enable_fuse,
      .jtag_enable_fuse, .tap_shifting, .tdo_data, .wake_pin_mask, .port_reset_n, .core_reset_n,
      .tdo_out, .tdo_oe, .jtag_enabled, .buf_enable_zero, .buf_enable_one, .comp_enable,
      .vref_enable, .bod_enable, .wdt_run, .main_clk_enable);
   rsp_far_model far_u (.hclk, .src_on, .wdt_fire, .shift_req, .tdo_bit, .por_n, .ext_reset_n,
      .wdt_expire, .bod_low, .jtag_reset_reg, .tap_shifting, .tdo_data);

   always #2.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         failures = failures + 1;
         finish_test;
      end
   end

   task automatic finish_test;
      if (failures == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (3) @(posedge hclk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
   endtask : rd

   // Cycles until the stretched reset lifts, bounded so a stuck reset ends the wait
   task automatic meas(input int lo, input int hi);
      int n;
      n = 0;
      while (core_reset_n !== 1'b1 && n < 1000) begin
         @(posedge hclk);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask : meas

   task automatic hit(input int k, input logic [2:0] c, input logic [15:0] t);
      startup_time_fuses <= c[2:1];
      clock_select_fuses <= {3'h0, c[0]};
      src_on[k]          <= 1'b1;
      #1;
      if (k < 2) begin
         chk(port_reset_n, 32'h0);
         chk(core_reset_n, 32'h0);
      end
      repeat (3) @(posedge hclk);
      chk(core_reset_n, 32'h0);
      src_on[k] <= 1'b0;
      meas(t, t + 4);
      chk(port_reset_n, 32'h1);
      rd(TOUT_OFF, {16'h0, t});
   endtask : hit

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      meas(TOUT_SHORT_CYC, TOUT_SHORT_CYC + 4);
      rd(CTRL_OFF, 32'h0);
      rd(INPUT_DISABLE_REG_ZERO_OFF, 32'h0);
      rd(INPUT_DISABLE_REG_ONE_OFF, 32'h0);
      hit(0, 3'd1, TOUT_SHORT_CYC);
      hit(0, 3'd2, TOUT_MID_CYC);
      hit(1, 3'd5, TOUT_LONG_CYC);
      hit(2, 3'd7, TOUT_XLONG_CYC);
      src_on[0] <= 1'b1;
      repeat (3) @(posedge hclk);
      src_on[0] <= 1'b0;
      repeat (100) @(posedge hclk);
      src_on[2] <= 1'b1;
      repeat (2) @(posedge hclk);
      src_on[2] <= 1'b0;
      meas(TOUT_XLONG_CYC, TOUT_XLONG_CYC + 4);
      hit(2, 3'd2, TOUT_MID_CYC);
      wdt_fire <= 1'b1;
      @(posedge hclk);
      wdt_fire <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(core_reset_n, 32'h1);
      wr(CTRL_OFF, 32'h100);
      wdt_fire <= 1'b1;
      @(posedge hclk);
      wdt_fire <= 1'b0;
      repeat (4) @(posedge hclk);
      chk(core_reset_n, 32'h0);
      meas(TOUT_MID_CYC - 6, TOUT_MID_CYC + 4);
      rd(CTRL_OFF, 32'h0);
      src_on[3] <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(core_reset_n, 32'h1);
      chk(vref_enable, 32'h0);
      src_on[3] <= 1'b0;
      brownout_level_fuses <= 3'b101;
      repeat (3) @(posedge hclk);
      chk(bod_enable, 32'h1);
      chk(vref_enable, 32'h1);
      hit(3, 3'd2, TOUT_MID_CYC);
      brownout_level_fuses <= BOD_DISABLED;
      wr(CTRL_OFF, 32'h080);
      chk(vref_enable, 32'h1);
      wr(CTRL_OFF, 32'h000);
      chk(vref_enable, 32'h0);
      wr(INPUT_DISABLE_REG_ZERO_OFF, 32'ha5);
      wr(INPUT_DISABLE_REG_ONE_OFF, 32'h3c);
      chk(buf_enable_zero, 32'h5a);
      chk(buf_enable_one, 32'hc3);
      rd(INPUT_DISABLE_REG_ONE_OFF, 32'h3c);
      wr(12'h020, 32'hffffffff);
      rd(12'h020, 32'h0);
      wr(INPUT_DISABLE_REG_ZERO_OFF, 32'h0);
      foreach (md[i]) begin
         wr(CTRL_OFF, 32'h121 | {28'h0, md[i], 1'b0});
         chk(buf_enable_zero, (md[i] > RSP_SLP_ADCNR) ? wake_pin_mask : 8'hff);
         chk(comp_enable, 32'(md[i] <= RSP_SLP_ADCNR));
         chk(main_clk_enable, 32'(md[i] != RSP_SLP_PWRDN && md[i] != RSP_SLP_PWRSAVE));
         chk(vref_enable, 32'h1);
         chk(wdt_run, 32'h1);
      end
      debug_enable_fuse <= 1'b1;
      wr(CTRL_OFF, 32'h125);
      chk(main_clk_enable, 32'h1);
      wr(CTRL_OFF, 32'h135);
      chk(jtag_enabled, 32'h0);
      wr(CTRL_OFF, 32'h000);
      chk(jtag_enabled, 32'h1);
      chk(tdo_oe, 32'h0);
      shift_req <= 1'b1;
      tdo_bit   <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(tdo_oe, 32'h1);
      chk(tdo_out, 32'h1);
      jtag_enable_fuse <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(jtag_enabled, 32'h0);
      chk(tdo_oe, 32'h0);
      chk(hresp, 32'h0);
      finish_test;
   end
endmodule : test_reset_and_sleep_power_control
